// ===== rtl/gpu_port.sv
// gpio port slice: axi4-lite register file, input sampling and pin drive
//
// Chosen here: the AXI4-Lite register port.
`default_nettype none
module gpu_port #(
    parameter int PINS = gpu_pkg::PIN_COUNT,
    parameter logic [31:0] LOWER_CONFIG_VALUE = 32'h44444444
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [PINS-1:0] pin_in,
    input wire logic [PINS-1:0] alt_out,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe,
    output logic [PINS-1:0] pin_analog
);
    import gpu_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    logic [31:0] upper_pin_config_q;
    logic [15:0] pin_output_latch_q;
    logic [PINS-1:0] input_level;

    // ****************************************
    // write channel
    // ****************************************
    logic aw_held_q;
    logic [7:0] aw_addr_q;
    logic w_held_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wr_fire;
    logic wr_known;
    logic [31:0] wr_mask;

    // both halves may arrive in either order; hold each until the other lands
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    // one strobe bit widens to a whole byte lane
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign wr_mask[8*lane +: 8] = {8{w_strb_q[lane]}};
        end
    endgenerate

    // ****************************************
    // write decode
    // ****************************************
    logic [5:0] wr_word;
    logic wr_sel_lower;
    logic wr_sel_config;
    logic wr_sel_level;
    logic wr_sel_latch;
    logic wr_sel_set_clear;

    assign wr_word = aw_addr_q[7:2];
    assign wr_sel_lower = (wr_word == 6'h00);
    assign wr_sel_config = (wr_word == UPPER_PIN_CONFIG_OFS[7:2]);
    assign wr_sel_level = (wr_word == PIN_INPUT_LEVEL_OFS[7:2]);
    assign wr_sel_latch = (wr_word == PIN_OUTPUT_LATCH_OFS[7:2]);
    assign wr_sel_set_clear = (wr_word == PIN_SET_CLEAR_OFS[7:2]);
    // lower config and input level accept a write but keep nothing
    assign wr_known = wr_sel_lower || wr_sel_config || wr_sel_level
        || wr_sel_latch || wr_sel_set_clear;

    // ****************************************
    // write response
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= AXI_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_known ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ****************************************
    // configuration register
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            upper_pin_config_q <= UPPER_PIN_CONFIG_RST;
        end else if (wr_fire && wr_sel_config) begin
            // byte lanes honoured; every field is plain read/write
            upper_pin_config_q <= (w_data_q & wr_mask)
                | (upper_pin_config_q & ~wr_mask);
        end
    end

    // ****************************************
    // output latch and set/clear
    // ****************************************
    logic [15:0] set_req;
    logic [15:0] clr_req;
    assign set_req = w_data_q[15:0];
    assign clr_req = w_data_q[CLEAR_FIELD_POS +: 16];

    // word access is the software's duty; partial strobes still write their latch lanes, set/clear ignores the strobes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_output_latch_q <= PIN_OUTPUT_LATCH_RST;
        end else if (wr_fire && wr_sel_latch) begin
            // upper half has no storage, so reserved writes are dropped
            pin_output_latch_q <= (w_data_q[15:0] & wr_mask[15:0])
                | (pin_output_latch_q & ~wr_mask[15:0]);
        end else if (wr_fire && wr_sel_set_clear) begin
            // set applied last so it beats a clear on the same pin
            pin_output_latch_q <= (pin_output_latch_q & ~clr_req)
                | set_req;
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [5:0] rd_word;
    logic [31:0] rd_value;
    logic [1:0] rd_resp;
    logic rd_sel_lower;
    logic rd_sel_config;
    logic rd_sel_level;
    logic rd_sel_latch;
    logic rd_sel_set_clear;
    logic rd_known;

    assign s_axi_arready = !rvalid_q;
    assign rd_word = s_axi_araddr[7:2];

    // ****************************************
    // read decode
    // ****************************************
    assign rd_sel_lower = (rd_word == 6'h00);
    assign rd_sel_config = (rd_word == UPPER_PIN_CONFIG_OFS[7:2]);
    assign rd_sel_level = (rd_word == PIN_INPUT_LEVEL_OFS[7:2]);
    assign rd_sel_latch = (rd_word == PIN_OUTPUT_LATCH_OFS[7:2]);
    assign rd_sel_set_clear = (rd_word == PIN_SET_CLEAR_OFS[7:2]);
    assign rd_known = rd_sel_lower || rd_sel_config || rd_sel_level
        || rd_sel_latch || rd_sel_set_clear;
    // unmapped words answer with an error and zero data
    assign rd_resp = rd_known ? AXI_RESP_OKAY : AXI_RESP_SLVERR;

    always_comb begin
        rd_value = 32'h00000000;
        if (rd_sel_lower) begin
            rd_value = LOWER_CONFIG_VALUE;
        end else if (rd_sel_config) begin
            rd_value = upper_pin_config_q;
        end else if (rd_sel_level) begin
            rd_value = {16'h0000, input_level};
        end else if (rd_sel_latch) begin
            rd_value = {16'h0000, pin_output_latch_q};
        end else if (rd_sel_set_clear) begin
            // write-only, so a read never exposes the request bits
            rd_value = 32'h00000000;
        end
    end

    // ****************************************
    // read response
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= AXI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_value;
            rresp_q <= rd_resp;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ****************************************
    // pins
    // ****************************************
    gpu_pin_sync #(
        .WIDTH(PINS)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_async(pin_in),
        .pin_level(input_level)
    );

    // ****************************************
    // pin fields and drive
    // ****************************************
    // lower pins have no register here and stay floating inputs
    logic [2*PINS-1:0] mode_all;
    logic [2*PINS-1:0] config_all;
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_fields
            if (g >= UPPER_PIN_BASE) begin : g_up
                localparam int B = (g - UPPER_PIN_BASE) * FIELD_GROUP_W;
                assign mode_all[2*g +: 2] = upper_pin_config_q[B + MODE_FIELD_POS +: 2];
                assign config_all[2*g +: 2] = upper_pin_config_q[B + CONFIG_FIELD_POS +: 2];
            end else begin : g_low
                assign mode_all[2*g +: 2] = MODE_INPUT;
                assign config_all[2*g +: 2] = CFG_IN_FLOATING;
            end
        end
    endgenerate

    gpu_pin_drive #(
        .WIDTH(PINS)
    ) u_drive (
        .aclk(aclk),
        .aresetn(aresetn),
        .mode_fields(mode_all),
        .config_fields(config_all),
        .latch(pin_output_latch_q[PINS-1:0]),
        .alt_out(alt_out),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .pin_analog(pin_analog)
    );
endmodule : gpu_port
`default_nettype wire

// ===== shared/gpu_pkg.sv
// package of offsets, field layouts and reset values for the gpio port slice
`default_nettype none
package gpu_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] UPPER_PIN_CONFIG_OFS = 8'h04;
    localparam logic [7:0] PIN_INPUT_LEVEL_OFS = 8'h08;
    localparam logic [7:0] PIN_OUTPUT_LATCH_OFS = 8'h0c;
    localparam logic [7:0] PIN_SET_CLEAR_OFS = 8'h10;
    // ****************************************
    // reset values and field layout
    // ****************************************
    localparam logic [31:0] UPPER_PIN_CONFIG_RST = 32'h44444444;
    localparam logic [15:0] PIN_OUTPUT_LATCH_RST = 16'h0000;
    localparam int PIN_COUNT = 16;
    localparam int UPPER_PIN_BASE = 8;
    localparam int FIELD_GROUP_W = 4;
    localparam int MODE_FIELD_POS = 0;
    localparam int CONFIG_FIELD_POS = 2;
    localparam int CLEAR_FIELD_POS = 16;
    localparam int SYNC_STAGES = 3;
    // ****************************************
    // field encodings
    // ****************************************
    localparam logic [1:0] MODE_INPUT = 2'h0;
    localparam logic [1:0] MODE_OUT_10MHZ = 2'h1;
    localparam logic [1:0] MODE_OUT_2MHZ = 2'h2;
    localparam logic [1:0] MODE_OUT_50MHZ = 2'h3;
    localparam logic [1:0] CFG_IN_ANALOG = 2'h0;
    localparam logic [1:0] CFG_IN_FLOATING = 2'h1;
    localparam logic [1:0] CFG_IN_PULLED = 2'h2;
    localparam logic [1:0] CFG_OUT_PUSH_PULL = 2'h0;
    localparam logic [1:0] CFG_OUT_OPEN_DRAIN = 2'h1;
    localparam logic [1:0] CFG_ALT_PUSH_PULL = 2'h2;
    localparam logic [1:0] CFG_ALT_OPEN_DRAIN = 2'h3;
    localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
    localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;
endpackage : gpu_pkg
`default_nettype wire

// ===== rtl/gpu_pin_sync.sv
// three-stage input synchroniser with agreement filter, one per pin
`default_nettype none
module gpu_pin_sync #(
    parameter int WIDTH = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_level
);
    import gpu_pkg::*;
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            meta_q <= pin_async;
            s2_q <= meta_q;
            s3_q <= s2_q;
        end
    end

    // a change counts only once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_filt
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    level_q[g] <= 1'b0;
                end else if (s2_q[g] == s3_q[g]) begin
                    level_q[g] <= s3_q[g];
                end
            end
        end
    endgenerate

    assign pin_level = level_q;
endmodule : gpu_pin_sync
`default_nettype wire

// ===== rtl/gpu_pin_drive.sv
// per-pin driver: decodes mode and configuration into output and enable
`default_nettype none
module gpu_pin_drive #(
    parameter int WIDTH = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2*WIDTH-1:0] mode_fields,
    input wire logic [2*WIDTH-1:0] config_fields,
    input wire logic [WIDTH-1:0] latch,
    input wire logic [WIDTH-1:0] alt_out,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pin_analog
);
    import gpu_pkg::*;
    logic [WIDTH-1:0] out_q;
    logic [WIDTH-1:0] oe_q;
    logic [WIDTH-1:0] ana_q;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_pin
            logic [1:0] md;
            logic [1:0] cf;
            logic src;
            assign md = mode_fields[2*g +: 2];
            assign cf = config_fields[2*g +: 2];
            // alternate configurations take the peripheral's value, latch is held
            assign src = cf[1] ? alt_out[g] : latch[g];
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    out_q[g] <= 1'b0;
                    oe_q[g] <= 1'b0;
                    ana_q[g] <= 1'b0;
                end else if (md == MODE_INPUT) begin
                    out_q[g] <= 1'b0;
                    oe_q[g] <= 1'b0;
                    ana_q[g] <= (cf == CFG_IN_ANALOG);
                end else begin
                    out_q[g] <= src;
                    // open drain only pulls low, released for a one
                    oe_q[g] <= cf[0] ? ~src : 1'b1;
                    ana_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign pin_out = out_q;
    assign pin_oe = oe_q;
    assign pin_analog = ana_q;
endmodule : gpu_pin_drive
`default_nettype wire

// ===== tb/gpu_port_assertions.sv
// assertion checker bound to the gpio port slice
`default_nettype none
module gpu_port_assertions #(
    parameter int PINS = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic [PINS-1:0] alt_out,
    input wire logic [PINS-1:0] pin_oe,
    input wire logic [PINS-1:0] pin_analog
);
    import gpu_pkg::*;
    // ****************************************
    // read address tracking and properties
    // ****************************************
    logic [7:0] rd_addr_q;
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_q <= s_axi_araddr;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_reset_no_drive: assert property ($rose(aresetn) |->
        pin_oe == '0 && pin_analog == '0) else $error("pins driven after reset");
    a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_level_upper_zero: assert property (s_axi_rvalid
        && rd_addr_q == PIN_INPUT_LEVEL_OFS |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("level upper half not zero");
    a_write_answer: assert property (aw_w_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    a_one_response: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_setclr_reads_zero: assert property (s_axi_rvalid
        && rd_addr_q == PIN_SET_CLEAR_OFS
        |-> s_axi_rdata == 32'h0 && s_axi_rresp == AXI_RESP_OKAY) else $error("set/clear read");
    a_analog_no_drive: assert property ((pin_analog & pin_oe) == '0)
        else $error("analog pin driven");
    a_low_pins_idle: assert property (pin_oe[7:0] == 8'h00
        && pin_analog[7:0] == 8'h00) else $error("lower pins driven");
    // drive may only move after a register write, unless the alternate source moved
    a_drive_after_write: assert property ($changed(pin_oe) &&
        $past(alt_out) == $past(alt_out, 2) |-> $past(s_axi_bvalid)) else $error("drive moved");
endmodule : gpu_port_assertions
bind gpu_port gpu_port_assertions #(.PINS(PINS)) chk_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .alt_out(alt_out),
    .pin_oe(pin_oe), .pin_analog(pin_analog));
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the gpio port slice
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import gpu_pkg::*;
    // ****************************************
    // stimulus, bus tasks and scenarios
    // ****************************************
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic [15:0] pin_in = 16'h0000, alt_out = 16'h0000, pin_out, pin_oe, pin_analog;
    int failures = 0, cmp_count = 0;
    logic [31:0] cfg_tab [7] = '{32'h44444444, 32'h0, 32'h11111111, 32'h22222222,
        32'h33333333, 32'h88888888, 32'h14444441};
    logic [15:0] oe_tab [7] = '{16'h0, 16'h0, 16'hff00, 16'hff00, 16'hff00, 16'h0, 16'h8100};
    logic [15:0] an_tab [7] = '{16'h0, 16'hff00, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    gpu_port dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
        .alt_out(alt_out), .pin_out(pin_out), .pin_oe(pin_oe), .pin_analog(pin_analog));
    always #20 aclk = ~aclk;
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n == 64) failures++;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 64) failures++;
    endtask : rd
    // pins follow a register one edge after the write answer; three edges leave margin
    task automatic settle();
        repeat (3) @(posedge aclk);
        #1;
    endtask : settle
    task automatic t_reset();
        rd(UPPER_PIN_CONFIG_OFS);
        check("config", d, UPPER_PIN_CONFIG_RST);
        rd(PIN_OUTPUT_LATCH_OFS);
        check("latch", d, 32'h0);
        rd(PIN_SET_CLEAR_OFS);
        check("setclr", d, 32'h0);
        check("oe", 32'(pin_oe), 32'h0);
        check("analog rst", 32'(pin_analog), 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_modes();
        for (int i = 0; i < 7; i++) begin
            wr(UPPER_PIN_CONFIG_OFS, cfg_tab[i]);
            rd(UPPER_PIN_CONFIG_OFS);
            check("config rb", d, cfg_tab[i]);
            check("config resp", 32'(r), 32'(AXI_RESP_OKAY));
            settle();
            check("oe", 32'(pin_oe), 32'(oe_tab[i]));
            check("analog", 32'(pin_analog), 32'(an_tab[i]));
        end
        $display("test modes done");
    endtask : t_modes
    task automatic t_latch();
        wr(UPPER_PIN_CONFIG_OFS, 32'h55551111);
        wr(PIN_OUTPUT_LATCH_OFS, 32'h0000a5a5);
        check("latch resp", 32'(r), 32'(AXI_RESP_OKAY));
        settle();
        check("out", 32'(pin_out[15:8]), 32'ha5);
        check("od oe", 32'(pin_oe[15:8]), 32'h5f);
        wr(PIN_SET_CLEAR_OFS, 32'h00010202);
        rd(PIN_OUTPUT_LATCH_OFS);
        check("set clr", d, 32'h0000a7a6);
        wr(PIN_SET_CLEAR_OFS, 32'h60004000);
        rd(PIN_OUTPUT_LATCH_OFS);
        check("both", d, 32'h0000c7a6);
        rd(PIN_SET_CLEAR_OFS);
        check("setclr wo", d, 32'h0);
        wr(PIN_SET_CLEAR_OFS, 32'h0);
        rd(PIN_OUTPUT_LATCH_OFS);
        check("none", d, 32'h0000c7a6);
        settle();
        check("out2", 32'(pin_out[15:8]), 32'hc7);
        $display("test latch done");
    endtask : t_latch
    task automatic t_alt();
        wr(UPPER_PIN_CONFIG_OFS, 32'h44444999);
        alt_out <= 16'h0500;
        settle();
        check("alt out", 32'(pin_out[10:8]), 32'h5);
        check("alt oe", 32'(pin_oe), 32'h0700);
        wr(UPPER_PIN_CONFIG_OFS, UPPER_PIN_CONFIG_RST);
        settle();
        check("idle oe", 32'(pin_oe), 32'h0);
        rd(PIN_OUTPUT_LATCH_OFS);
        check("held", d, 32'h0000c7a6);
        $display("test alt done");
    endtask : t_alt
    task automatic t_input();
        @(posedge aclk);
        pin_in <= 16'h3c5a;
        repeat (8) @(posedge aclk);
        rd(PIN_INPUT_LEVEL_OFS);
        check("level", d, 32'h00003c5a);
        check("level resp", 32'(r), 32'(AXI_RESP_OKAY));
        wr(PIN_INPUT_LEVEL_OFS, 32'h0000ffff);
        rd(PIN_INPUT_LEVEL_OFS);
        check("level ro", d, 32'h00003c5a);
        wr(8'h20, 32'h1);
        check("wr unmapped", 32'(r), 32'(AXI_RESP_SLVERR));
        rd(8'h20);
        check("rd unmapped", 32'(r), 32'(AXI_RESP_SLVERR));
        $display("test input done");
    endtask : t_input
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (5000) @(posedge aclk);
        failures++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_modes();
        t_latch();
        t_alt();
        t_input();
        summarize();
    end
endmodule : tb_top
`default_nettype wire
